// [sbf_pkg_pulse.sv]
// constants for the sync and burst flag timing block, plus its one-shot pulse timer
package sbf_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CLK_HZ = 40_000_000;
  localparam int REF_HZ = 31_500;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int DIV_A = 7;
  localparam int DIV_B = 5;
  localparam int DIV_C = 5;
  localparam int DIV_D = 3;
  localparam int IDX_W = 10;
  localparam int CNT_W = 16;
  // half-line positions within a field
  localparam int EQ1_END_HL = 6;
  localparam int VS_END_HL = 12;
  localparam int EQ2_END_HL = 18;
  localparam int VDRIVE_HL = 18;
  localparam int VBLANK_HL = 40;
  // times in ns, cycles derived at the pclk rate
  localparam int HDRIVE_NS = 6350;
  localparam int HBLANK_NS = 11000;
  localparam int HSYNC_START_NS = 1500;
  localparam int HSYNC_NS = 4750;
  localparam int EQ_NS = 2375;
  localparam int SERR_NS = 4750;
  localparam int BDELAY_NS = 5000;
  localparam int BFLAG_NS = 2500;
  localparam int VGATE_NS = 571500;
  localparam int HDRIVE_CYC = HDRIVE_NS * CLK_MHZ / 1000;
  localparam int HBLANK_CYC = HBLANK_NS * CLK_MHZ / 1000;
  localparam int HSYNC_START_CYC = HSYNC_START_NS * CLK_MHZ / 1000;
  localparam int HSYNC_CYC = HSYNC_NS * CLK_MHZ / 1000;
  localparam int EQ_CYC = EQ_NS * CLK_MHZ / 1000;
  localparam int SERR_CYC = SERR_NS * CLK_MHZ / 1000;
  localparam int BDELAY_CYC = BDELAY_NS * CLK_MHZ / 1000;
  localparam int BFLAG_CYC = BFLAG_NS * CLK_MHZ / 1000;
  localparam int VGATE_CYC = VGATE_NS * CLK_MHZ / 1000;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VGATE = 8'h04;
  localparam logic [7:0] ADDR_BDELAY = 8'h08;
  localparam logic [7:0] ADDR_BFLAG = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_VGATE_BIT = 16;
  localparam int ST_EXTSEEN_BIT = 17;
  localparam int ST_FIELD_BIT = 18;
endpackage

`timescale 1ns/100ps
module sbf_pulse #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trig,
  input wire logic [W-1:0] len,
  output logic active,
  output logic done
);
  logic [W-1:0] cnt_q;

  // retrigger while running is ignored; zero length ends at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      active <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!active) begin
        if (trig) begin
          if (len == '0) begin
            done <= 1'b1;
          end else begin
            cnt_q <= len;
            active <= 1'b1;
          end
        end
      end else if (cnt_q == W'(1)) begin
        active <= 1'b0;
        done <= 1'b1;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end
endmodule

// [sbf_top.sv]
// sync generator with external reference option and burst flag generator, APB registers
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module sbf_top #(
  parameter int VGATE_DEF = sbf_pkg::VGATE_CYC,
  parameter int REF_DIV = sbf_pkg::REF_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_ref,
  output logic hdrive,
  output logic hblank,
  output logic hsync,
  output logic vdrive,
  output logic vblank,
  output logic comp_sync,
  output logic comp_blank,
  output logic burst_flag
);
  localparam int CW = sbf_pkg::CNT_W;
  localparam int IW = sbf_pkg::IDX_W;

  function automatic logic in_win(input logic [CW-1:0] c, input int st, input int w);
    return (int'(c) >= st) && (int'(c) < st + w);
  endfunction

  function automatic logic [IW-1:0] hl_index(input logic [2:0] a, input logic [2:0] b,
                                             input logic [2:0] c, input logic [1:0] d);
    int v;
    v = int'(a) + sbf_pkg::DIV_A * (int'(b) + sbf_pkg::DIV_B * (int'(c) + sbf_pkg::DIV_C * int'(d)));
    return IW'(v);
  endfunction

  // registers
  logic ext_sel_q;
  logic [CW-1:0] vgate_w_q;
  logic [CW-1:0] bdelay_w_q;
  logic [CW-1:0] bflag_w_q;
  logic ext_seen_q;
  logic field_q;

  logic setup;
  assign setup = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_q <= 1'b0;
      vgate_w_q <= CW'(VGATE_DEF);
      bdelay_w_q <= CW'(sbf_pkg::BDELAY_CYC);
      bflag_w_q <= CW'(sbf_pkg::BFLAG_CYC);
    end else if (psel && penable && pwrite) begin
      unique case (paddr)
        sbf_pkg::ADDR_CTRL: ext_sel_q <= pwdata[sbf_pkg::CTRL_EXT_BIT];
        sbf_pkg::ADDR_VGATE: vgate_w_q <= pwdata[CW-1:0];
        sbf_pkg::ADDR_BDELAY: bdelay_w_q <= pwdata[CW-1:0];
        sbf_pkg::ADDR_BFLAG: bflag_w_q <= pwdata[CW-1:0];
        default: ;
      endcase
    end
  end

  function automatic logic addr_ok(input logic [7:0] a);
    return a == sbf_pkg::ADDR_CTRL || a == sbf_pkg::ADDR_VGATE || a == sbf_pkg::ADDR_BDELAY ||
           a == sbf_pkg::ADDR_BFLAG || a == sbf_pkg::ADDR_STATUS;
  endfunction

  // answer in the single access cycle after setup: no wait states
  logic [IW-1:0] idx;
  logic vgate_act;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok(paddr);
      if (setup && !pwrite) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          sbf_pkg::ADDR_CTRL: prdata[sbf_pkg::CTRL_EXT_BIT] <= ext_sel_q;
          sbf_pkg::ADDR_VGATE: prdata[CW-1:0] <= vgate_w_q;
          sbf_pkg::ADDR_BDELAY: prdata[CW-1:0] <= bdelay_w_q;
          sbf_pkg::ADDR_BFLAG: prdata[CW-1:0] <= bflag_w_q;
          sbf_pkg::ADDR_STATUS: begin
            prdata[IW-1:0] <= idx;
            prdata[sbf_pkg::ST_VGATE_BIT] <= vgate_act;
            prdata[sbf_pkg::ST_EXTSEEN_BIT] <= ext_seen_q;
            prdata[sbf_pkg::ST_FIELD_BIT] <= field_q;
          end
          default: ;
        endcase
      end
    end
  end

  // external reference: two-stage synchroniser, then edge detect
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_ref;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  logic ext_edge;
  assign ext_edge = ext_s2_q & ~ext_s3_q;

  // sticky: external edges have arrived since last read of status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_seen_q <= 1'b0;
    end else if (ext_edge) begin
      ext_seen_q <= 1'b1;
    end else if (setup && !pwrite && paddr == sbf_pkg::ADDR_STATUS) begin
      ext_seen_q <= 1'b0;
    end
  end

  // internal reference divider
  logic [CW-1:0] odiv_q;
  logic int_tick;
  assign int_tick = (odiv_q == CW'(REF_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odiv_q <= '0;
    end else if (int_tick) begin
      odiv_q <= '0;
    end else begin
      odiv_q <= odiv_q + CW'(1);
    end
  end

  // no external edges means timing halts; that is intended when locked to a dead source
  logic ref_tick;
  assign ref_tick = ext_sel_q ? ext_edge : int_tick;

  // half-line chain 7,5,5,3 and line parity
  logic [2:0] ca_q;
  logic [2:0] cb_q;
  logic [2:0] cc_q;
  logic [1:0] cd_q;
  logic div2_q;
  logic [CW-1:0] hl_cnt_q;
  logic [CW-1:0] hl_len_q;
  logic [CW-1:0] h_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca_q <= '0;
      cb_q <= '0;
      cc_q <= '0;
      cd_q <= '0;
      div2_q <= 1'b0;
      field_q <= 1'b0;
    end else if (ref_tick) begin
      div2_q <= ~div2_q;
      if (ca_q != 3'(sbf_pkg::DIV_A - 1)) begin
        ca_q <= ca_q + 3'd1;
      end else begin
        ca_q <= '0;
        if (cb_q != 3'(sbf_pkg::DIV_B - 1)) begin
          cb_q <= cb_q + 3'd1;
        end else begin
          cb_q <= '0;
          if (cc_q != 3'(sbf_pkg::DIV_C - 1)) begin
            cc_q <= cc_q + 3'd1;
          end else begin
            cc_q <= '0;
            if (cd_q != 2'(sbf_pkg::DIV_D - 1)) begin
              cd_q <= cd_q + 2'd1;
            end else begin
              cd_q <= '0;
              field_q <= ~field_q;
            end
          end
        end
      end
    end
  end
  // idx is the index of the half-line just begun at the last tick
  assign idx = hl_index(ca_q, cb_q, cc_q, cd_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hl_cnt_q <= '0;
      hl_len_q <= CW'(REF_DIV);
      h_cnt_q <= '1;
    end else begin
      if (ref_tick) begin
        hl_cnt_q <= '0;
        hl_len_q <= hl_cnt_q + CW'(1);
      end else if (hl_cnt_q != '1) begin
        hl_cnt_q <= hl_cnt_q + CW'(1);
      end
      if (ref_tick && div2_q) begin
        h_cnt_q <= '0;
      end else if (h_cnt_q != '1) begin
        h_cnt_q <= h_cnt_q + CW'(1);
      end
    end
  end

  // waveform decode
  logic eq_iv;
  logic vs_iv;
  logic hd_d;
  logic hs_d;
  logic broad;
  assign eq_iv = (int'(idx) < sbf_pkg::EQ1_END_HL) ||
                 (int'(idx) >= sbf_pkg::VS_END_HL && int'(idx) < sbf_pkg::EQ2_END_HL);
  assign vs_iv = int'(idx) >= sbf_pkg::EQ1_END_HL && int'(idx) < sbf_pkg::VS_END_HL;
  assign hd_d = in_win(h_cnt_q, 0, sbf_pkg::HDRIVE_CYC);
  assign hs_d = in_win(h_cnt_q, sbf_pkg::HSYNC_START_CYC, sbf_pkg::HSYNC_CYC);
  assign broad = int'(hl_cnt_q) + sbf_pkg::SERR_CYC < int'(hl_len_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdrive <= 1'b0;
      hblank <= 1'b0;
      hsync <= 1'b0;
      vdrive <= 1'b0;
      vblank <= 1'b0;
      comp_sync <= 1'b0;
      comp_blank <= 1'b0;
    end else begin
      hdrive <= hd_d;
      hblank <= in_win(h_cnt_q, 0, sbf_pkg::HBLANK_CYC);
      hsync <= hs_d;
      vdrive <= int'(idx) < sbf_pkg::VDRIVE_HL;
      vblank <= int'(idx) < sbf_pkg::VBLANK_HL;
      comp_blank <= in_win(h_cnt_q, 0, sbf_pkg::HBLANK_CYC) || int'(idx) < sbf_pkg::VBLANK_HL;
      if (eq_iv) begin
        comp_sync <= in_win(hl_cnt_q, 0, sbf_pkg::EQ_CYC);
      end else if (vs_iv) begin
        comp_sync <= broad;
      end else begin
        comp_sync <= hs_d;
      end
    end
  end

  // burst flag chain driven from the horizontal drive output
  logic hdrive_d1_q;
  logic vdrive_d1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdrive_d1_q <= 1'b0;
      vdrive_d1_q <= 1'b0;
    end else begin
      hdrive_d1_q <= hdrive;
      vdrive_d1_q <= vdrive;
    end
  end
  logic hd_rise;
  logic vd_rise;
  logic delay_done;
  logic flag_act;
  assign hd_rise = hdrive & ~hdrive_d1_q;
  assign vd_rise = vdrive & ~vdrive_d1_q;

  sbf_pulse #(.W(CW)) u_vgate (
    .clk(pclk),
    .rst_n(presetn),
    .trig(vd_rise),
    .len(vgate_w_q),
    .active(vgate_act),
    .done()
  );

  // vd_rise covers the cycle before the gate timer goes active
  sbf_pulse #(.W(CW)) u_bdelay (
    .clk(pclk),
    .rst_n(presetn),
    .trig(hd_rise & ~vgate_act & ~vd_rise),
    .len(bdelay_w_q),
    .active(),
    .done(delay_done)
  );

  sbf_pulse #(.W(CW)) u_bflag (
    .clk(pclk),
    .rst_n(presetn),
    .trig(delay_done),
    .len(bflag_w_q),
    .active(flag_act),
    .done()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_flag <= 1'b0;
    end else begin
      burst_flag <= flag_act;
    end
  end
endmodule

// [sbf_top_props.sv]
// assertion checker for the sync and burst flag timing block
`timescale 1ns/100ps
module sbf_top_props #(
  parameter int VGATE_DEF = sbf_pkg::VGATE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hdrive,
  input wire logic hblank,
  input wire logic vdrive,
  input wire logic vblank,
  input wire logic comp_sync,
  input wire logic comp_blank,
  input wire logic burst_flag
);
  logic vd_q;
  logic hd_q;
  logic [15:0] vg_cnt_q;
  logic [15:0] hd_cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ages since the last vdrive and hdrive leading edges, saturating so idle time never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vd_q <= 1'h0;
      hd_q <= 1'h0;
      vg_cnt_q <= 16'hFFFF;
      hd_cnt_q <= 16'hFFFF;
    end else begin
      vd_q <= vdrive;
      hd_q <= hdrive;
      vg_cnt_q <= (vdrive && !vd_q) ? 16'h0000 : vg_cnt_q + {15'h0000, vg_cnt_q != 16'hFFFF};
      hd_cnt_q <= (hdrive && !hd_q) ? 16'h0000 : hd_cnt_q + {15'h0000, hd_cnt_q != 16'hFFFF};
    end
  end
  a_apb_ready: assert property (psel && !penable |=> pready) else $error("ready missing after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_unmapped: assert property (psel && !penable && !pwrite && paddr > 8'h10 |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_gate_quiet: assert property (vg_cnt_q < VGATE_DEF |-> !$rose(burst_flag))
    else $error("flag inside vertical gate");
  a_flag_after_drive: assert property ($rose(burst_flag) |-> hd_cnt_q >= 16'h0002 && hd_cnt_q <= 16'h012C)
    else $error("flag not tied to drive edge");
  a_eq_at_field: assert property ($rose(vdrive) |-> ##[0:2] comp_sync) else $error("no pulse at field start");
  a_sync_in_blank: assert property ($rose(comp_sync) && !vblank |-> hblank) else $error("sync outside blanking");
  a_vert_in_blank: assert property (vdrive |-> vblank) else $error("vertical drive outside blanking");
  a_blank_comp: assert property ($rose(vblank) |-> ##[0:1] comp_blank) else $error("blanking not combined");
endmodule

bind sbf_top sbf_top_props #(.VGATE_DEF(VGATE_DEF)) u_sbf_top_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .hdrive, .hblank, .vdrive, .vblank, .comp_sync, .comp_blank, .burst_flag
);

// [sbf_ref_source.sv]
// reference source model standing in for the counted-down subcarrier
`timescale 1ns/100ps
module sbf_ref_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [15:0] period,
  output logic ext_ref
);
  logic [15:0] cnt_q;
  // the divide by 455 and times four is folded into one period count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      ext_ref <= 1'h0;
    end else if (!en) begin
      // no edges at all while off, so the block has to freeze
      cnt_q <= 16'h0000;
      ext_ref <= 1'h0;
    end else begin
      cnt_q <= (cnt_q >= period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      ext_ref <= (cnt_q < (period >> 1));
    end
  end
endmodule

// [tb.sv]
// bench: register access, line and field timing, burst flag keying
`timescale 1ns/100ps
module tb;
  localparam int VG = 3000;
  localparam int RD = 600;
  localparam int BD = 40;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_ref, hdrive, hblank, hsync, vdrive, vblank, comp_sync, comp_blank, burst_flag;
  logic src_en = 1'h0;
  logic [15:0] src_period = 16'h0258;
  logic [3:0] p_q = 4'h0;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int nfl = 0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    p_q <= {comp_sync, burst_flag, vdrive, hdrive};
  end
  sbf_top #(.VGATE_DEF(VG), .REF_DIV(RD)) u_sbf_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_ref, .hdrive, .hblank, .hsync, .vdrive, .vblank,
    .comp_sync, .comp_blank, .burst_flag);
  sbf_ref_source u_sbf_ref_source (.clk(pclk), .rst_n(presetn), .en(src_en), .period(src_period), .ext_ref);
  function automatic logic rose(input int w);
    logic [3:0] s;
    s = {comp_sync, burst_flag, vdrive, hdrive};
    return s[w] & ~p_q[w];
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      errors++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'h1, a, wd, d, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'h0, a, 32'h0, d, e);
    chk(d, exp);
  endtask
  // bounded wait for a leading edge; flag edges are tallied on the way
  task automatic wait_rise(input int w, input int lim, output int t);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (rose(2)) nfl++;
    end while (!rose(w) && n < lim);
    t = cyc;
    if (!rose(w)) begin
      errors++;
      final_report();
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [31:0] s0;
    logic e;
    int t0, t1, n, fi, fo, bad, f0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, VG);
    rdchk(8'h08, 32'hC8);
    rdchk(8'h0C, 32'h64);
    apb(1'h0, 8'h14, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    wr(8'h08, BD);
    wr(8'h0C, 32'h14);
    rdchk(8'h08, BD);
    rdchk(8'h0C, 32'h14);
    $display("test registers done");
    // a field is far longer than the run, so a mid-run reset restarts it at half-line 0
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    wait_rise(1, 20, t0);
    bad = 0;
    fi = 0;
    fo = 0;
    t1 = 0;
    // every half-line in the vertical interval must carry one pulse start
    while (vdrive === 1'h1 && cyc - t0 < 20000) begin
      @(negedge pclk);
      if (rose(3) && t1 != 0 && cyc - t1 != RD) bad++;
      if (rose(3)) t1 = cyc;
      if (rose(2) && cyc - t0 < VG) fi++;
      if (rose(2) && cyc - t0 >= VG) fo++;
    end
    chk(cyc - t0, 18 * RD);
    chk(bad, 0);
    chk(fi, 0);
    chk(fo > 0, 1);
    $display("test vertical interval done");
    rdchk(8'h08, 32'hC8);
    rdchk(8'h0C, 32'h64);
    wr(8'h08, BD);
    wr(8'h0C, 32'h14);
    wait_rise(0, 1300, t0);
    wait_rise(2, 400, t1);
    chk(t1 - t0 > BD && t1 - t0 <= BD + 4, 1);
    n = 0;
    while (burst_flag === 1'h1 && n < 500) begin
      @(negedge pclk);
      n++;
    end
    chk(n, 32'h14);
    chk({hsync, hblank, hdrive}, 3'h7);
    wr(8'h0C, 32'h0);
    f0 = nfl;
    wait_rise(0, 1300, t1);
    chk(t1 - t0, 2 * RD);
    chk({hsync, hblank}, 2'h1);
    // zero flag width: the delay still runs but no flag may follow
    repeat (BD + 10) begin
      @(negedge pclk);
      if (rose(2)) nfl++;
    end
    chk(nfl - f0, 0);
    $display("test line timing done");
    wr(8'h00, 32'h1);
    apb(1'h0, 8'h10, 32'h0, s0, e);
    repeat (1300) @(posedge pclk);
    apb(1'h0, 8'h10, 32'h0, d, e);
    chk(d[9:0], s0[9:0]);
    src_en <= 1'h1;
    wait_rise(0, 3000, t0);
    wait_rise(0, 1300, t1);
    chk(t1 - t0, 2 * RD);
    apb(1'h0, 8'h10, 32'h0, d, e);
    chk(d[17], 1);
    $display("test external reference done");
    src_period <= 16'h0014;
    wait_rise(1, 12000, t0);
    f0 = nfl;
    wait_rise(1, 12000, t1);
    chk(t1 - t0, 525 * 20);
    chk(nfl - f0, 0);
    $display("test field count done");
    final_report();
  end
endmodule
